// file: dfs_fault_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Faults stop the drive, raise fault output
// - Warnings raise warning output, drive keeps running
// - Fault output stays on while fault present
// - Three code lines show problem type
// - Clear input resets alarm after cause removed
// - Fault type decides whether running may resume
// - Panel request also resets the alarm
// - Any warning-class condition raises warning output
// - Warning alone puts warning code on lines
// - Fault and warning together: fault code wins
// - Ready only after power-on initialisation completes
// - Ready drops whenever a fault occurs
// - Functions reach terminals only when assigned
// - Polarity 0 low active, 1 high active
// - Duplicate terminal assignment raises configuration fault
module dfs_fault_status
(
   // Clock and reset.
   input  wire logic                                       ref_clk_in,
   input  wire logic                                       sys_rst_in,
   // Problem detectors on the drive clock.
   input  wire logic                                       fault_detect_in,
   input  wire logic [dfs_pkg::CODE_W-1:0]                 fault_code_in,
   input  wire logic                                       fault_resumable_in,
   input  wire logic                                       warn_detect_in,
   input  wire logic [dfs_pkg::CODE_W-1:0]                 warn_code_in,
   input  wire logic                                       init_done_in,
   // Reset requests: external pin and local panel pulse.
   input  wire logic                                       fault_clear_input,
   input  wire logic                                       panel_clear_in,
   // Other status functions and terminal configuration.
   input  wire logic [dfs_pkg::NUM_FUNCS-1:0]              aux_func_in,
   input  wire logic [dfs_pkg::NUM_TERMINALS-1:0][4:0]     output_function_index_in,
   input  wire logic [dfs_pkg::NUM_TERMINALS-1:0]          polarity_in,
   // Status toward the drive and the host.
   output logic                                            fault_output,
   output logic                                            warning_out,
   output logic                                            fault_code_line_1,
   output logic                                            fault_code_line_2,
   output logic                                            fault_code_line_3,
   output logic                                            ready_out,
   output logic                                            drive_stop_out,
   output logic                                            config_fault_out,
   output logic      [dfs_pkg::NUM_TERMINALS-1:0]          terminal_out
);
   import dfs_pkg::*;

   logic                   clr_s1;
   logic                   clr_s2;
   logic                   clr_s3;
   logic                   clr_level;
   logic                   next_clr_level;
   logic                   clr_accept;
   logic                   fault_latched;
   logic                   next_fault_latched;
   logic [CODE_W-1:0]      code_latched;
   logic [CODE_W-1:0]      next_code_latched;
   logic                   resumable;
   logic                   next_resumable;
   logic                   run_lock;
   logic                   next_run_lock;
   logic                   warning;
   logic                   next_warning;
   logic [CODE_W-1:0]      code_lines;
   logic [CODE_W-1:0]      next_code_lines;
   logic                   ready;
   logic                   next_ready;
   logic                   stop;
   logic                   next_stop;
   logic                   cfg_fault;
   logic                   fault_now;
   logic [NUM_FUNCS-1:0]   func_state;

   // The clear pin passes three flops; a level counts once stages two and three agree.
   always_comb
   begin
      next_clr_level = (clr_s2 == clr_s3) ? clr_s3 : clr_level;
   end

   // Synchroniser stages and the agreed clear level.
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         clr_s1    <= 1'b0;
         clr_s2    <= 1'b0;
         clr_s3    <= 1'b0;
         clr_level <= 1'b0;
      end
      else
      begin
         clr_s1    <= fault_clear_input;
         clr_s2    <= clr_s1;
         clr_s3    <= clr_s2;
         clr_level <= next_clr_level;
      end
   end

   // A reset request is the rising clear level or a panel pulse.
   assign clr_accept = (next_clr_level & ~clr_level) | panel_clear_in;

   // Any fault source present this cycle, including a bad terminal setup.
   assign fault_now = fault_detect_in | cfg_fault;

   // Fault latch: a new fault beats a clear in the same cycle.
   always_comb
   begin
      next_fault_latched = fault_latched;
      next_code_latched  = code_latched;
      next_resumable     = resumable;
      next_run_lock      = run_lock;
      if (fault_now)
      begin
         next_fault_latched = 1'b1;
         if (!fault_latched)
         begin
            next_code_latched = cfg_fault ? CODE_CONFIG_FAULT : fault_code_in;
            next_resumable    = fault_resumable_in & ~cfg_fault;
         end
      end
      else if (fault_latched && clr_accept)
      begin
         next_fault_latched = 1'b0;
         next_code_latched  = CODE_NONE;
         // A run lock, once set, lasts until the next system reset.
         next_run_lock      = run_lock | ~resumable;
      end
   end

   // Outputs: warning, priority code, ready and stop.
   always_comb
   begin
      next_warning    = warn_detect_in;
      next_code_lines = next_fault_latched ? next_code_latched :
                        (warn_detect_in ? warn_code_in : CODE_NONE);
      next_stop       = next_fault_latched | next_run_lock;
      next_ready      = init_done_in & ~next_stop;
   end

   // Registers the fault latch and the status outputs.
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         fault_latched <= 1'b0;
         code_latched  <= RST_CODE;
         resumable     <= 1'b0;
         run_lock      <= 1'b0;
         warning       <= 1'b0;
         code_lines    <= RST_CODE;
         ready         <= 1'b0;
         stop          <= 1'b0;
      end
      else
      begin
         fault_latched <= next_fault_latched;
         code_latched  <= next_code_latched;
         resumable     <= next_resumable;
         run_lock      <= next_run_lock;
         warning       <= next_warning;
         code_lines    <= next_code_lines;
         ready         <= next_ready;
         stop          <= next_stop;
      end
   end

   // Collects the function states that the terminals may carry.
   always_comb
   begin
      func_state                  = aux_func_in;
      func_state[FUNC_NONE]       = 1'b0;
      func_state[FUNC_READY]      = ready;
      func_state[FUNC_WARNING]    = warning;
      func_state[FUNC_FAULT]      = fault_latched;
      func_state[FUNC_CODE_LINE1] = code_lines[0];
      func_state[FUNC_CODE_LINE2] = code_lines[1];
      func_state[FUNC_CODE_LINE3] = code_lines[2];
   end

   // Terminal routing with polarity and duplicate detection.
   dfs_terminal_map u_map
   (
      .ref_clk_in    (ref_clk_in),
      .sys_rst_in    (sys_rst_in),
      .func_state_in (func_state),
      .func_idx_in   (output_function_index_in),
      .polarity_in   (polarity_in),
      .terminal_out  (terminal_out),
      .duplicate_out (cfg_fault)
   );

   // Status outputs straight from flops.
   assign fault_output      = fault_latched;
   assign warning_out       = warning;
   assign fault_code_line_1 = code_lines[0];
   assign fault_code_line_2 = code_lines[1];
   assign fault_code_line_3 = code_lines[2];
   assign ready_out         = ready;
   assign drive_stop_out    = stop;
   assign config_fault_out  = cfg_fault;

   fault_sets_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fault_detect_in |=> fault_output && drive_stop_out)
      else $error("fault did not raise fault output and stop");

   fault_holds_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fault_output && !clr_accept |=> fault_output)
      else $error("fault output dropped without a reset request");

   clear_ok_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fault_output && clr_accept && !fault_now |=> !fault_output)
      else $error("accepted reset did not clear the fault");

   warn_no_stop_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      warn_detect_in && !fault_output && !run_lock && !fault_now |=> warning_out && !drive_stop_out)
      else $error("warning stopped the drive or was not shown");

   warn_code_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      warn_detect_in && !next_fault_latched |=> code_lines == $past(warn_code_in))
      else $error("warning code not shown on code lines");

   fault_prio_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fault_detect_in && !fault_output && !cfg_fault ##1 warn_detect_in && !clr_accept
      |=> code_lines == $past(fault_code_in, 2) && warning_out && fault_output)
      else $error("fault code did not take priority over warning");

   ready_rule_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ready_out |-> !fault_output && $past(init_done_in))
      else $error("ready shown during fault or before initialisation");

   lock_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fault_output && !resumable && clr_accept && !fault_now |=> !ready_out [*2])
      else $error("non-resumable fault allowed running after reset");
endmodule // dfs_fault_status

// file: dfs_pkg.sv
package dfs_pkg;
   // Sizes of the output terminal set and of the function index.
   localparam int unsigned NUM_TERMINALS = 8;
   localparam int unsigned FUNC_IDX_W    = 5;
   localparam int unsigned NUM_FUNCS     = 18;
   localparam int unsigned CODE_W        = 3;

   // Output function indices; index zero means the terminal is unassigned.
   localparam logic [4:0] FUNC_NONE       = 5'h00;
   localparam logic [4:0] FUNC_READY      = 5'h01;
   localparam logic [4:0] FUNC_WARNING    = 5'h0a;
   localparam logic [4:0] FUNC_FAULT      = 5'h0b;
   localparam logic [4:0] FUNC_CODE_LINE1 = 5'h0c;
   localparam logic [4:0] FUNC_CODE_LINE2 = 5'h0d;
   localparam logic [4:0] FUNC_CODE_LINE3 = 5'h0e;
   localparam logic [4:0] FUNC_LAST       = 5'h11;

   // Terminal polarity settings.
   localparam logic POL_LOW_ACTIVE  = 1'b0;
   localparam logic POL_HIGH_ACTIVE = 1'b1;

   // Code shown when one function is assigned to two terminals, and the idle code.
   localparam logic [2:0] CODE_CONFIG_FAULT = 3'h7;
   localparam logic [2:0] CODE_NONE         = 3'h0;

   // Reset values.
   localparam logic [2:0]  RST_CODE = 3'h0;
   localparam logic [17:0] RST_FUNC = 18'h00000;
endpackage : dfs_pkg

// file: dfs_terminal_map.sv
`timescale 1ns/1ps
// Routes status functions onto output terminals, applies polarity, flags duplicates.
module dfs_terminal_map
(
   // Clock and reset.
   input  wire logic                                       ref_clk_in,
   input  wire logic                                       sys_rst_in,
   // Function states and terminal configuration.
   input  wire logic [dfs_pkg::NUM_FUNCS-1:0]              func_state_in,
   input  wire logic [dfs_pkg::NUM_TERMINALS-1:0][4:0]     func_idx_in,
   input  wire logic [dfs_pkg::NUM_TERMINALS-1:0]          polarity_in,
   // Terminal levels and duplicate detection.
   output logic      [dfs_pkg::NUM_TERMINALS-1:0]          terminal_out,
   output logic                                            duplicate_out
);
   import dfs_pkg::*;

   logic [NUM_TERMINALS-1:0] next_terminal;
   logic                     next_duplicate;

   // True for an index that names a real status function.
   function automatic logic func_assigned(input logic [4:0] idx);
      return (idx != FUNC_NONE) && (idx <= FUNC_LAST);
   endfunction

   // Looks up whether a function index is assigned and currently active.
   function automatic logic func_active(input logic [4:0] idx,
                                        input logic [NUM_FUNCS-1:0] state);
      if (!func_assigned(idx))
         return 1'b0;
      return state[idx];
   endfunction

   // Drives each terminal; unassigned terminals sit at their inactive level.
   always_comb
   begin
      next_terminal  = '0;
      next_duplicate = 1'b0;
      for (int t = 0; t < NUM_TERMINALS; t++)
      begin
         next_terminal[t] = func_active(func_idx_in[t], func_state_in)
                            ~^ polarity_in[t];
         for (int u = t + 1; u < NUM_TERMINALS; u++)
         begin
            // Out-of-range indices are unassigned, so they never collide.
            if (func_assigned(func_idx_in[t]) && func_idx_in[t] == func_idx_in[u])
               next_duplicate = 1'b1;
         end
      end
   end

   // Registers terminal levels and the duplicate flag.
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         terminal_out  <= '0;
         duplicate_out <= 1'b0;
      end
      else
      begin
         terminal_out  <= next_terminal;
         duplicate_out <= next_duplicate;
      end
   end
endmodule // dfs_terminal_map

// file: dfs_host_model.sv
`timescale 1ns/1ps
// Host controller: pulses the clear pin on request and cuts main power on a fault.
module dfs_host_model
(
   // Clock and reset.
   input  wire logic ref_clk_in,
   input  wire logic sys_rst_in,
   // Fault output from the drive and a clear request from the bench.
   input  wire logic fault_in,
   input  wire logic clear_req_in,
   // Clear pin toward the drive and main power state.
   output logic      clear_pin_out,
   output logic      main_power_out
);
   logic [2:0] hold;

   // Holds the pin high four cycles so the drive's synchroniser sees the edge.
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         hold <= 3'h0;
      else if (clear_req_in)
         hold <= 3'h4;
      else if (hold != 3'h0)
         hold <= hold - 3'h1;
   end
   assign clear_pin_out = (hold != 3'h0);
   // Main power is removed while the fault output is on.
   assign main_power_out = ~fault_in;
endmodule // dfs_host_model

// file: drive_fault_status_outputs_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the fault, warning, code and ready outputs.
module drive_fault_status_outputs_tb_top;
   import dfs_pkg::*;
   logic                          clk, rst, fdet, fres, wdet, init, panel, creq, cpin, mpow;
   logic [2:0]                    fcode, wcode, c, w;
   logic [NUM_FUNCS-1:0]          aux;
   logic [NUM_TERMINALS-1:0][4:0] idx;
   logic [NUM_TERMINALS-1:0]      pol, term;
   logic                          fo, wo, l1, l2, l3, rdy, stp, cfg;
   int                            fails, n_tests, cyc;

   // Clock of 25 ns.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Design and host model.
   dfs_fault_status i_dfs_fault_status (.ref_clk_in(clk), .sys_rst_in(rst),
      .fault_detect_in(fdet), .fault_code_in(fcode), .fault_resumable_in(fres),
      .warn_detect_in(wdet), .warn_code_in(wcode), .init_done_in(init),
      .fault_clear_input(cpin), .panel_clear_in(panel), .aux_func_in(aux),
      .output_function_index_in(idx), .polarity_in(pol), .fault_output(fo),
      .warning_out(wo), .fault_code_line_1(l1), .fault_code_line_2(l2),
      .fault_code_line_3(l3), .ready_out(rdy), .drive_stop_out(stp),
      .config_fault_out(cfg), .terminal_out(term));
   dfs_host_model i_dfs_host_model (.ref_clk_in(clk), .sys_rst_in(rst), .fault_in(fo),
      .clear_req_in(creq), .clear_pin_out(cpin), .main_power_out(mpow));

   // Advances n edges and settles just after the last one.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // Compares and counts one value.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected terminal levels: 1 fault, 2 warning, 3 function 2, others unassigned or out of range.
   function automatic logic [7:0] exp_term(input logic f, input logic wn, input logic a);
      return {4'h0, a, wn, f, 1'b0} ^ ~pol;
   endfunction

   // Holds reset three cycles and checks outputs are low meanwhile.
   task automatic do_reset();
      rst = 1'b1;
      step(3);
      chk({fo, wo, l3, l2, l1, rdy, stp, cfg}, 8'h00);
      chk(term, 8'h00);
      rst = 1'b0;
      step(1);
   endtask

   // Prints counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         report_and_stop();
      end
   end

   // Main sequence.
   initial
   begin
      {fdet, fres, wdet, init, panel, creq} = '0;
      {fcode, wcode, aux, idx} = '0;
      void'($urandom(15));
      pol = 8'($urandom);
      idx[1] = FUNC_FAULT;
      idx[2] = FUNC_WARNING;
      idx[3] = 5'h02;
      idx[6] = 5'h1f;
      idx[7] = 5'h1f;
      do_reset();
      step(2);
      chk(rdy, 1'b0);
      init = 1'b1;
      step(2);
      chk(rdy, 1'b1);
      chk(term, exp_term(1'b0, 1'b0, 1'b0));
      chk(cfg, 1'b0);
      $display("Test ready done");
      // Resumable faults, refused while the cause holds, then cleared from the panel.
      repeat (4)
      begin
         c = 3'($urandom_range(6, 1));
         aux = 18'($urandom);
         fdet = 1'b1;
         fcode = c;
         fres = 1'b1;
         step(1);
         chk({fo, stp, rdy, l3, l2, l1}, {3'b110, c});
         chk(mpow, 1'b0);
         step(1);
         chk(term, exp_term(1'b1, 1'b0, aux[2]));
         fcode = ~c;
         panel = 1'b1;
         step(1);
         panel = 1'b0;
         chk({fo, l3, l2, l1}, {1'b1, c});
         fdet = 1'b0;
         step(3);
         chk({fo, l3, l2, l1}, {1'b1, c});
         panel = 1'b1;
         step(1);
         panel = 1'b0;
         chk({fo, l3, l2, l1}, 8'h00);
         step(1);
         chk({rdy, stp}, 2'b10);
         chk(mpow, 1'b1);
      end
      $display("Test panel clear done");
      // Warning alone, then with a non-resumable fault, cleared by the pin.
      w = 3'($urandom_range(6, 1));
      wdet = 1'b1;
      wcode = w;
      step(1);
      chk({wo, fo, stp, l3, l2, l1}, {3'b100, w});
      fdet = 1'b1;
      fcode = c;
      fres = 1'b0;
      step(1);
      chk({wo, fo, l3, l2, l1}, {2'b11, c});
      step(1);
      chk(term, exp_term(1'b1, 1'b1, aux[2]));
      fdet = 1'b0;
      wdet = 1'b0;
      creq = 1'b1;
      step(1);
      creq = 1'b0;
      repeat (8) if (fo) step(1);
      chk({fo, wo}, 2'b00);
      chk({stp, rdy}, 2'b10);
      $display("Test warning and pin clear done");
      // Same function on two terminals raises a configuration fault.
      do_reset();
      step(2);
      idx[4] = FUNC_READY;
      idx[5] = FUNC_READY;
      step(1);
      chk(cfg, 1'b1);
      step(1);
      chk({fo, stp, rdy, l3, l2, l1}, {3'b110, CODE_CONFIG_FAULT});
      idx[5] = FUNC_NONE;
      step(2);
      panel = 1'b1;
      step(1);
      panel = 1'b0;
      chk({fo, stp}, 2'b01);
      $display("Test configuration fault done");
      do_reset();
      report_and_stop();
   end
endmodule // drive_fault_status_outputs_tb_top
